/* design/ambient_light_level_readout.sv */
// Dark-level comparator and light result registers behind a serial port.
//
// What this block does
// - Input below dark threshold selects dark level.
// - Dark threshold code: 0.54 uA per step.
// - Above threshold plus hysteresis returns to office.
// - Dark hysteresis uses same 0.54 uA scale.
// - Sensor one result: 13 bits, two registers.
// - Sensor two result in its own pair.
// - Low byte bits 7:0, high byte 12:8.
// - Enabled sensor results refresh every 80 ms.
// - Result registers are read-only; writes ignored.
// - Office threshold and hysteresis select office/daylight.
// - Dark decision overrides office decision.
// - Dark comparator acts only when enabled.
module ambient_light_level_readout #(
   parameter int REFRESH_CYCLES = light_readout_pkg::REFRESH_CYCLES,
   parameter logic [light_readout_pkg::DEV_ADDR_W-1:0] DEVICE_ADDR =
      light_readout_pkg::DEVICE_ADDR_DEFAULT
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Serial register port
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   // Light sensor conversions
   input wire logic [light_readout_pkg::RESULT_W-1:0] first_light_input_i,
   input wire logic [light_readout_pkg::RESULT_W-1:0] second_light_input_i,
   input wire logic [light_readout_pkg::NUM_SENSORS-1:0] sensor_enable_i,
   // Comparator controls
   input wire logic [light_readout_pkg::NUM_SENSORS-1:0]
      dark_comparator_enable_i,
   input wire logic [light_readout_pkg::CODE_W-1:0] office_threshold_i,
   input wire logic [light_readout_pkg::CODE_W-1:0] office_hysteresis_i,
   // Level selects, one bit per sensor
   output logic [light_readout_pkg::NUM_SENSORS-1:0] daylight_mode_o,
   output logic [light_readout_pkg::NUM_SENSORS-1:0] office_mode_o,
   output logic [light_readout_pkg::NUM_SENSORS-1:0] dark_mode_o,
   output logic refresh_o
);

   // ==========================================================
   // Local sizes
   localparam int CNT_W = $clog2(REFRESH_CYCLES);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(REFRESH_CYCLES - 1);
   localparam int RW = light_readout_pkg::RESULT_W;
   localparam int CW = light_readout_pkg::CODE_W;
   localparam int NS = light_readout_pkg::NUM_SENSORS;

   // ==========================================================
   // State
   typedef struct packed {
      logic [CW-1:0] dark_threshold;
      logic [CW-1:0] dark_hysteresis;
      logic [NS-1:0][RW-1:0] result;
      light_readout_pkg::level_e [NS-1:0] level;
      logic [CNT_W-1:0] refresh_cnt;
      logic refresh;
   } readout_s;

   readout_s s_r;
   readout_s s_nxt;

   logic [light_readout_pkg::ADDR_W-1:0] rd_addr;
   logic [CW-1:0] rd_data;
   logic wr;
   logic [light_readout_pkg::ADDR_W-1:0] wr_addr;
   logic [CW-1:0] wr_data;
   logic [NS-1:0][RW-1:0] live_input;

   assign live_input = {second_light_input_i, first_light_input_i};

   // ==========================================================
   // Level decision for one sensor
   // Both result and dark codes count in 0.54 uA steps, so they
   // compare directly; office codes are scaled up to that unit.
   function automatic light_readout_pkg::level_e next_level(
      input light_readout_pkg::level_e cur,
      input logic [RW-1:0] value,
      input logic [CW-1:0] dark_thr,
      input logic [CW-1:0] dark_hys,
      input logic dark_en,
      input logic [CW-1:0] office_thr,
      input logic [CW-1:0] office_hys
   );
      logic [RW-1:0] dark_trip;
      logic [RW-1:0] dark_release;
      logic [RW-1:0] office_trip;
      logic [RW-1:0] office_release;
      logic dark_low;
      logic dark_high;
      light_readout_pkg::level_e lvl;
      dark_trip = RW'(dark_thr);
      dark_release = RW'(dark_thr) + RW'(dark_hys);
      office_trip = RW'(office_thr) << light_readout_pkg::OFFICE_SHIFT;
      office_release = (RW'(office_thr) + RW'(office_hys))
         << light_readout_pkg::OFFICE_SHIFT;
      dark_low = dark_en && (value < dark_trip);
      dark_high = value > dark_release;
      lvl = cur;
      if (dark_low) begin
         // Dark wins over whatever the office comparator says.
         lvl = light_readout_pkg::LEVEL_DARK;
      end else if (cur == light_readout_pkg::LEVEL_DARK) begin
         // A disabled dark comparator cannot hold the dark level.
         if (dark_high || !dark_en) begin
            lvl = light_readout_pkg::LEVEL_OFFICE;
         end
      end else if (value < office_trip) begin
         lvl = light_readout_pkg::LEVEL_OFFICE;
      end else if (value > office_release) begin
         lvl = light_readout_pkg::LEVEL_DAYLIGHT;
      end
      return lvl;
   endfunction

   // ==========================================================
   // Register read decode
   function automatic logic [CW-1:0] read_reg(
      input logic [light_readout_pkg::ADDR_W-1:0] addr,
      input readout_s st
   );
      logic [CW-1:0] d;
      d = light_readout_pkg::UNMAPPED_READ;
      unique case (addr)
         light_readout_pkg::ADDR_DARK_THRESHOLD: begin
            d = st.dark_threshold;
         end
         light_readout_pkg::ADDR_DARK_HYSTERESIS: begin
            d = st.dark_hysteresis;
         end
         light_readout_pkg::ADDR_ONE_LOW: begin
            d = st.result[0][light_readout_pkg::LSB_W-1:0];
         end
         light_readout_pkg::ADDR_ONE_HIGH: begin
            d = {light_readout_pkg::HIGH_RESERVED,
               st.result[0][RW-1:light_readout_pkg::LSB_W]};
         end
         light_readout_pkg::ADDR_TWO_LOW: begin
            d = st.result[1][light_readout_pkg::LSB_W-1:0];
         end
         light_readout_pkg::ADDR_TWO_HIGH: begin
            d = {light_readout_pkg::HIGH_RESERVED,
               st.result[1][RW-1:light_readout_pkg::LSB_W]};
         end
         default: begin
            d = light_readout_pkg::UNMAPPED_READ;
         end
      endcase
      return d;
   endfunction

   assign rd_data = read_reg(rd_addr, s_r);

   // ==========================================================
   // Serial port
   serial_register_port #(
      .DEVICE_ADDR(DEVICE_ADDR)
   ) u_port (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n_o),
      .rd_addr_o(rd_addr),
      .rd_data_i(rd_data),
      .wr_o(wr),
      .wr_addr_o(wr_addr),
      .wr_data_o(wr_data)
   );

   // ==========================================================
   // Next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.refresh = 1'b0;
      // Only the two comparator settings accept writes; results and
      // unmapped offsets drop the byte silently.
      if (wr) begin
         unique case (wr_addr)
            light_readout_pkg::ADDR_DARK_THRESHOLD: begin
               s_nxt.dark_threshold = wr_data;
            end
            light_readout_pkg::ADDR_DARK_HYSTERESIS: begin
               s_nxt.dark_hysteresis = wr_data;
            end
            default: begin
               s_nxt.dark_threshold = s_r.dark_threshold;
            end
         endcase
      end
      if (s_r.refresh_cnt == CNT_LAST) begin
         s_nxt.refresh_cnt = '0;
         s_nxt.refresh = 1'b1;
      end else begin
         s_nxt.refresh_cnt = s_r.refresh_cnt + 1'b1;
      end
      // Results and levels move together on the refresh tick, so the
      // level always reflects the value software can read back.
      if (s_r.refresh) begin
         for (int i = 0; i < NS; i++) begin
            if (sensor_enable_i[i]) begin
               s_nxt.result[i] = live_input[i];
               s_nxt.level[i] = next_level(s_r.level[i], live_input[i],
                  s_r.dark_threshold, s_r.dark_hysteresis,
                  dark_comparator_enable_i[i], office_threshold_i,
                  office_hysteresis_i);
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '{dark_threshold: light_readout_pkg::DARK_THRESHOLD_RST,
            dark_hysteresis: light_readout_pkg::DARK_HYSTERESIS_RST,
            result: {NS{light_readout_pkg::RESULT_RST}},
            level: '{NS{light_readout_pkg::LEVEL_DAYLIGHT}},
            refresh_cnt: '0, refresh: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Outputs
   always_comb begin
      for (int i = 0; i < NS; i++) begin
         daylight_mode_o[i] =
            s_r.level[i] == light_readout_pkg::LEVEL_DAYLIGHT;
         office_mode_o[i] = s_r.level[i] == light_readout_pkg::LEVEL_OFFICE;
         dark_mode_o[i] = s_r.level[i] == light_readout_pkg::LEVEL_DARK;
      end
   end

   assign refresh_o = s_r.refresh;

endmodule

/* design/light_readout_pkg.sv */
// Constants, register map and types shared by the light level readout.
package light_readout_pkg;

   // ==========================================================
   // Clock and refresh timing
   localparam int CLK_FREQ_KHZ = 50000;
   localparam int REFRESH_TIME_MS = 80;
   localparam int REFRESH_CYCLES = REFRESH_TIME_MS * CLK_FREQ_KHZ;

   // ==========================================================
   // Result and code widths
   localparam int NUM_SENSORS = 2;
   localparam int RESULT_W = 13;
   localparam int LSB_W = 8;
   localparam int MSB_W = RESULT_W - LSB_W;
   localparam int CODE_W = 8;
   localparam int ADDR_W = 8;
   localparam int DEV_ADDR_W = 7;
   localparam int BIT_CNT_W = 3;

   // ==========================================================
   // Photocurrent scales in nanoamps
   localparam int DARK_STEP_NA = 540;
   localparam int DARK_FULL_NA = 137700;
   // One result count equals one dark code step.
   localparam int RESULT_STEP_NA = DARK_STEP_NA;
   localparam int OFFICE_STEP_NA = 4300;
   // Office codes are scaled by a shift; 4300 / 540 is close to 8.
   localparam int OFFICE_SHIFT = 3;

   // ==========================================================
   // Register offsets
   localparam logic [ADDR_W-1:0] ADDR_DARK_THRESHOLD = 8'h1F;
   localparam logic [ADDR_W-1:0] ADDR_DARK_HYSTERESIS = 8'h20;
   localparam logic [ADDR_W-1:0] ADDR_ONE_LOW = 8'h21;
   localparam logic [ADDR_W-1:0] ADDR_ONE_HIGH = 8'h22;
   localparam logic [ADDR_W-1:0] ADDR_TWO_LOW = 8'h23;
   localparam logic [ADDR_W-1:0] ADDR_TWO_HIGH = 8'h24;

   // ==========================================================
   // Reset and fill values
   localparam logic [CODE_W-1:0] DARK_THRESHOLD_RST = 8'h00;
   localparam logic [CODE_W-1:0] DARK_HYSTERESIS_RST = 8'h00;
   localparam logic [RESULT_W-1:0] RESULT_RST = 13'h0000;
   localparam logic [CODE_W-1:0] UNMAPPED_READ = 8'h00;
   localparam logic [2:0] HIGH_RESERVED = 3'h0;
   // Arbitrary neutral bus address.
   localparam logic [DEV_ADDR_W-1:0] DEVICE_ADDR_DEFAULT = 7'h2A;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      LEVEL_DAYLIGHT,
      LEVEL_OFFICE,
      LEVEL_DARK
   } level_e;

   typedef enum logic [2:0] {
      PORT_IDLE,
      PORT_ADDR,
      PORT_ADDR_ACK,
      PORT_WRITE,
      PORT_WRITE_ACK,
      PORT_READ,
      PORT_READ_ACK
   } port_state_e;

endpackage

/* design/serial_register_port.sv */
// Two-wire serial slave giving byte access to a register space.
module serial_register_port #(
   parameter logic [light_readout_pkg::DEV_ADDR_W-1:0] DEVICE_ADDR =
      light_readout_pkg::DEVICE_ADDR_DEFAULT
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Serial pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   // Register side
   output logic [light_readout_pkg::ADDR_W-1:0] rd_addr_o,
   input wire logic [light_readout_pkg::CODE_W-1:0] rd_data_i,
   output logic wr_o,
   output logic [light_readout_pkg::ADDR_W-1:0] wr_addr_o,
   output logic [light_readout_pkg::CODE_W-1:0] wr_data_o
);

   // ==========================================================
   // State
   typedef struct packed {
      logic scl_q;
      logic sda_q;
      light_readout_pkg::port_state_e state;
      logic [light_readout_pkg::BIT_CNT_W-1:0] bit_cnt;
      logic full;
      logic pointer_phase;
      logic rw;
      logic [light_readout_pkg::CODE_W-1:0] shift;
      logic [light_readout_pkg::ADDR_W-1:0] ptr;
      logic drive;
      logic wr;
      logic [light_readout_pkg::ADDR_W-1:0] wr_addr;
      logic [light_readout_pkg::CODE_W-1:0] wr_data;
   } port_s;

   port_s s_r;
   port_s s_nxt;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   localparam logic [light_readout_pkg::BIT_CNT_W-1:0] LAST_BIT = 3'h7;

   assign scl_rise = scl_i && !s_r.scl_q;
   assign scl_fall = !scl_i && s_r.scl_q;
   assign start_seen = scl_i && s_r.scl_q && s_r.sda_q && !sda_i;
   assign stop_seen = scl_i && s_r.scl_q && !s_r.sda_q && sda_i;

   // ==========================================================
   // Protocol engine
   always_comb begin
      s_nxt = s_r;
      s_nxt.scl_q = scl_i;
      s_nxt.sda_q = sda_i;
      s_nxt.wr = 1'b0;
      if (start_seen) begin
         s_nxt.state = light_readout_pkg::PORT_ADDR;
         s_nxt.bit_cnt = '0;
         s_nxt.full = 1'b0;
         s_nxt.pointer_phase = 1'b1;
         s_nxt.drive = 1'b0;
      end else if (stop_seen) begin
         s_nxt.state = light_readout_pkg::PORT_IDLE;
         s_nxt.drive = 1'b0;
      end else if (scl_rise) begin
         unique case (s_r.state)
            light_readout_pkg::PORT_ADDR,
            light_readout_pkg::PORT_WRITE: begin
               s_nxt.shift = {s_r.shift[light_readout_pkg::CODE_W-2:0], sda_i};
               s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
               s_nxt.full = (s_r.bit_cnt == LAST_BIT);
            end
            light_readout_pkg::PORT_READ_ACK: begin
               // A not-acknowledge from the host ends the read burst.
               if (sda_i) begin
                  s_nxt.state = light_readout_pkg::PORT_IDLE;
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         unique case (s_r.state)
            light_readout_pkg::PORT_ADDR: begin
               if (s_r.full) begin
                  s_nxt.full = 1'b0;
                  s_nxt.rw = s_r.shift[0];
                  if (s_r.shift[light_readout_pkg::CODE_W-1:1] == DEVICE_ADDR)
                  begin
                     s_nxt.state = light_readout_pkg::PORT_ADDR_ACK;
                     s_nxt.drive = 1'b1;
                  end else begin
                     s_nxt.state = light_readout_pkg::PORT_IDLE;
                  end
               end
            end
            light_readout_pkg::PORT_ADDR_ACK: begin
               s_nxt.bit_cnt = '0;
               if (s_r.rw) begin
                  s_nxt.state = light_readout_pkg::PORT_READ;
                  s_nxt.shift = rd_data_i;
                  s_nxt.drive = !rd_data_i[light_readout_pkg::CODE_W-1];
                  s_nxt.ptr = s_r.ptr + 1'b1;
               end else begin
                  s_nxt.state = light_readout_pkg::PORT_WRITE;
                  s_nxt.drive = 1'b0;
               end
            end
            light_readout_pkg::PORT_WRITE: begin
               if (s_r.full) begin
                  s_nxt.full = 1'b0;
                  s_nxt.state = light_readout_pkg::PORT_WRITE_ACK;
                  s_nxt.drive = 1'b1;
                  if (s_r.pointer_phase) begin
                     s_nxt.pointer_phase = 1'b0;
                     s_nxt.ptr = s_r.shift;
                  end else begin
                     s_nxt.wr = 1'b1;
                     s_nxt.wr_addr = s_r.ptr;
                     s_nxt.wr_data = s_r.shift;
                     s_nxt.ptr = s_r.ptr + 1'b1;
                  end
               end
            end
            light_readout_pkg::PORT_WRITE_ACK: begin
               s_nxt.state = light_readout_pkg::PORT_WRITE;
               s_nxt.drive = 1'b0;
            end
            light_readout_pkg::PORT_READ: begin
               s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
               s_nxt.shift = {s_r.shift[light_readout_pkg::CODE_W-2:0], 1'b0};
               if (s_r.bit_cnt == LAST_BIT) begin
                  s_nxt.state = light_readout_pkg::PORT_READ_ACK;
                  s_nxt.drive = 1'b0;
               end else begin
                  s_nxt.drive = !s_r.shift[light_readout_pkg::CODE_W-2];
               end
            end
            light_readout_pkg::PORT_READ_ACK: begin
               s_nxt.state = light_readout_pkg::PORT_READ;
               s_nxt.bit_cnt = '0;
               s_nxt.shift = rd_data_i;
               s_nxt.drive = !rd_data_i[light_readout_pkg::CODE_W-1];
               s_nxt.ptr = s_r.ptr + 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '{scl_q: 1'b1, sda_q: 1'b1,
            state: light_readout_pkg::PORT_IDLE, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_n_o = !s_r.drive;
   assign rd_addr_o = s_r.ptr;
   assign wr_o = s_r.wr;
   assign wr_addr_o = s_r.wr_addr;
   assign wr_data_o = s_r.wr_data;

endmodule

/* bench/readout_assertions.sv */
// Checker for refresh spacing and level selects of the light readout.
module readout_assertions #(
   parameter int REFRESH_CYCLES = light_readout_pkg::REFRESH_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Sensor side
   input wire logic [light_readout_pkg::RESULT_W-1:0] first_light_input_i,
   input wire logic [1:0] sensor_enable_i,
   input wire logic [1:0] dark_comparator_enable_i,
   input wire logic [7:0] office_threshold_i,
   input wire logic [7:0] office_hysteresis_i,
   // Level selects
   input wire logic [1:0] daylight_mode_o,
   input wire logic [1:0] office_mode_o,
   input wire logic [1:0] dark_mode_o,
   input wire logic refresh_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // ==========================================================
   // Helper logic
   // The first gap after reset is not exact, so only later gaps are timed.
   logic [31:0] gap_r;
   logic seen_r;
   wire logic [8:0] top =
      {1'b0, office_threshold_i} + {1'b0, office_hysteresis_i};
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gap_r <= 32'h0;
         seen_r <= 1'b0;
      end else if (refresh_o) begin
         gap_r <= 32'h0;
         seen_r <= 1'b1;
      end else begin
         gap_r <= gap_r + 32'h1;
      end
   end

   sequence s_tick_one;
      refresh_o && sensor_enable_i[0];
   endsequence
   sequence s_office_only;
      s_tick_one ##0 !dark_comparator_enable_i[0];
   endsequence

   // ==========================================================
   // Assertions
   chk_refresh_gap: assert property (
      refresh_o && seen_r |-> gap_r == REFRESH_CYCLES - 1)
      else $error("refresh spacing wrong");
   chk_refresh_bound: assert property (
      gap_r <= REFRESH_CYCLES) else $error("refresh missing");
   chk_level_onehot: assert property (
      $onehot({dark_mode_o[0], office_mode_o[0], daylight_mode_o[0]}) &&
      $onehot({dark_mode_o[1], office_mode_o[1], daylight_mode_o[1]}))
      else $error("level select not one-hot");
   chk_level_hold: assert property (
      !$past(refresh_o) |-> $stable(dark_mode_o) && $stable(office_mode_o)
      && $stable(daylight_mode_o)) else $error("level moved off refresh");
   chk_dark_disabled: assert property (
      s_office_only |=> !dark_mode_o[0]) else $error("dark while disabled");
   chk_office_entry: assert property (
      s_office_only ##0
      (first_light_input_i < {2'h0, office_threshold_i, 3'h0})
      |=> office_mode_o[0]) else $error("office level not taken");
   chk_daylight_entry: assert property (
      s_office_only ##0 !dark_mode_o[0] ##0
      (first_light_input_i > {1'h0, top, 3'h0})
      |=> daylight_mode_o[0]) else $error("daylight level not taken");
   chk_idle_keep: assert property (
      refresh_o && !sensor_enable_i[0] |=>
      $stable({dark_mode_o[0], office_mode_o[0], daylight_mode_o[0]}))
      else $error("disabled sensor level moved");
endmodule

bind ambient_light_level_readout readout_assertions #(
   .REFRESH_CYCLES(REFRESH_CYCLES)
) chk (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .first_light_input_i(first_light_input_i),
   .sensor_enable_i(sensor_enable_i),
   .dark_comparator_enable_i(dark_comparator_enable_i),
   .office_threshold_i(office_threshold_i),
   .office_hysteresis_i(office_hysteresis_i),
   .daylight_mode_o(daylight_mode_o),
   .office_mode_o(office_mode_o),
   .dark_mode_o(dark_mode_o),
   .refresh_o(refresh_o)
);

/* bench/serial_host_model.sv */
// Two-wire bus master standing in for the host processor.
module serial_host_model (
   // Clock and bus
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released data reads high through the pull-up.
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // Phases of 3 and 5 clocks keep the port's sampling margins.
   task automatic bit_io(input logic b, output logic r);
      hold(3);
      sda_o = b;
      hold(5);
      scl_o = 1'b1;
      hold(5);
      r = sda_i;
      scl_o = 1'b0;
   endtask
   task automatic start();
      if (!scl_o) begin
         hold(3);
         sda_o = 1'b1;
         hold(5);
         scl_o = 1'b1;
         hold(5);
      end
      sda_o = 1'b0;
      hold(5);
      scl_o = 1'b0;
   endtask
   task automatic stop();
      hold(3);
      sda_o = 1'b0;
      hold(5);
      scl_o = 1'b1;
      hold(5);
      sda_o = 1'b1;
      hold(5);
   endtask
   task automatic xfer(input logic [7:0] tx, input logic ack_in,
                       output logic [7:0] rx, output logic ack_out);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(ack_in, ack_out);
   endtask
   task automatic reg_write(input logic [6:0] dev, input logic [7:0] a,
                            input logic [7:0] d, output logic nak);
      logic [7:0] rx;
      logic k0, k1, k2;
      start();
      xfer({dev, 1'b0}, 1'b1, rx, k0);
      xfer(a, 1'b1, rx, k1);
      xfer(d, 1'b1, rx, k2);
      stop();
      nak = k0 | k1 | k2;
   endtask
   task automatic reg_read(input logic [6:0] dev, input logic [7:0] a,
                           output logic [7:0] d, output logic nak);
      logic [7:0] rx;
      logic k0, k1, k2, k3;
      start();
      xfer({dev, 1'b0}, 1'b1, rx, k0);
      xfer(a, 1'b1, rx, k1);
      start();
      xfer({dev, 1'b1}, 1'b1, rx, k2);
      xfer(8'hFF, 1'b1, d, k3);
      stop();
      nak = k0 | k1 | k2;
   endtask
endmodule

/* bench/testbench.sv */
// Self-checking testbench for the ambient light level readout.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // A short refresh period keeps the run small.
   localparam int P = 64;
   localparam logic [6:0] DEV = light_readout_pkg::DEVICE_ADDR_DEFAULT;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic scl, host_sda, sda_o, sda_oe_n_o, refresh;
   logic [12:0] first_in = 13'h0000;
   logic [12:0] second_in = 13'h0000;
   logic [1:0] sens_en = 2'b00;
   logic [1:0] dark_en = 2'b00;
   logic [7:0] off_thr = 8'h00;
   logic [7:0] off_hys = 8'h00;
   logic [1:0] day_m, off_m, dark_m;
   wire logic sda = host_sda & (sda_oe_n_o | sda_o);
   int error_cnt = 0;
   int n_tests = 0;

   initial begin
      forever #10 clk_i = ~clk_i;
   end

   serial_host_model host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
      .sda_o(host_sda));
   ambient_light_level_readout #(.REFRESH_CYCLES(P)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
      .first_light_input_i(first_in), .second_light_input_i(second_in),
      .sensor_enable_i(sens_en), .dark_comparator_enable_i(dark_en),
      .office_threshold_i(off_thr), .office_hysteresis_i(off_hys),
      .daylight_mode_o(day_m), .office_mode_o(off_m),
      .dark_mode_o(dark_m), .refresh_o(refresh));

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic nak;
      host.reg_write(DEV, a, d, nak);
      check(nak, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      logic nak;
      host.reg_read(DEV, a, v, nak);
      check({nak, v}, {1'b0, exp});
   endtask
   task automatic tick();
      int n = 0;
      while (refresh !== 1'b1 && n < 2 * P) begin
         @(negedge clk_i);
         n++;
      end
      check(refresh, 1'b1);
      repeat (2) @(negedge clk_i);
   endtask
   task automatic step(input logic [12:0] v, input logic [2:0] exp);
      first_in = v;
      tick();
      check({dark_m[0], off_m[0], day_m[0]}, exp);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      check({sda_oe_n_o, refresh, dark_m, off_m, day_m}, 8'h83);
      rd(8'h1F, 8'h00);
      rd(8'h20, 8'h00);
      rd(8'h21, 8'h00);
      rd(8'h24, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_regs();
      logic nak;
      wr(8'h1F, 8'hA5);
      rd(8'h1F, 8'hA5);
      wr(8'h20, 8'h5A);
      rd(8'h20, 8'h5A);
      rd(8'h30, 8'h00);
      host.reg_write(7'h15, 8'h1F, 8'h00, nak);
      check(nak, 1'b1);
      rd(8'h1F, 8'hA5);
      $display("test registers done");
   endtask
   task automatic t_results();
      first_in = 13'h1ABC;
      second_in = 13'h0F35;
      sens_en = 2'b11;
      tick();
      rd(8'h21, 8'hBC);
      rd(8'h22, 8'h1A);
      rd(8'h23, 8'h35);
      rd(8'h24, 8'h0F);
      sens_en = 2'b10;
      first_in = 13'h1FFF;
      second_in = 13'h1FFF;
      tick();
      rd(8'h21, 8'hBC);
      rd(8'h24, 8'h1F);
      wr(8'h22, 8'hFF);
      rd(8'h22, 8'h1A);
      wr(8'h23, 8'h00);
      rd(8'h23, 8'hFF);
      $display("test results done");
   endtask
   task automatic t_dark();
      sens_en = 2'b11;
      dark_en = 2'b11;
      second_in = 13'h1000;
      wr(8'h1F, 8'h10);
      wr(8'h20, 8'h08);
      step(13'h000F, 3'b100);
      step(13'h0018, 3'b100);
      step(13'h0019, 3'b010);
      check({dark_m[1], off_m[1], day_m[1]}, 3'b001);
      dark_en = 2'b10;
      step(13'h000F, 3'b001);
      dark_en = 2'b11;
      step(13'h0010, 3'b001);
      $display("test dark done");
   endtask
   task automatic t_office();
      dark_en = 2'b10;
      off_thr = 8'h04;
      off_hys = 8'h02;
      step(13'h001F, 3'b010);
      step(13'h0030, 3'b010);
      step(13'h0031, 3'b001);
      dark_en = 2'b11;
      step(13'h000F, 3'b100);
      $display("test office done");
   endtask

   initial begin
      repeat (8) @(negedge clk_i);
      rst_i = 1'b0;
      @(negedge clk_i);
      t_reset();
      t_regs();
      t_results();
      t_dark();
      t_office();
      close_out();
   end
   initial begin
      #1500000;
      error_cnt++;
      close_out();
   end
endmodule
